// File: hdl/ulb_consts.vh
`ifndef ULB_CONSTS_VH
`define ULB_CONSTS_VH
// Register byte addresses.
`define ULB_A_CTRL 8'h00
`define ULB_A_OPT 8'h04
`define ULB_A_STAT 8'h08
`define ULB_A_TX 8'h0C
`define ULB_A_RX 8'h10
`define ULB_A_DIV 8'h14
// Control register fields.
`define ULB_C_PWR 0
`define ULB_C_TXE 1
`define ULB_C_RXE 2
`define ULB_C_PS_LO 3
`define ULB_C_PS_HI 4
`define ULB_C_LEN7 5
`define ULB_C_STOP2 6
`define ULB_C_MSB 7
// Option register fields.
`define ULB_O_SBL_LO 0
`define ULB_O_SBL_HI 2
`define ULB_O_TINV 3
`define ULB_O_STT 4
`define ULB_O_SRF 5
// Status register fields.
`define ULB_S_OVE 0
`define ULB_S_FE 1
`define ULB_S_PE 2
`define ULB_S_TSF 7
// Reset values.
`define ULB_RST_CTRL 8'h00
`define ULB_RST_OPT 8'h05
`define ULB_RST_DATA 8'hFF
`define ULB_RST_DIV 8'hFF
// Parity modes.
`define ULB_PS_NONE 2'h0
`define ULB_PS_ZERO 2'h1
`define ULB_PS_ODD 2'h2
`define ULB_PS_EVEN 2'h3
// Break timing in bit times.
`define ULB_BRK_BASE 5'h0D
`define ULB_BRK_RX_MIN 5'h0B
// AXI responses.
`define ULB_RESP_OK 2'h0
`define ULB_RESP_ERR 2'h2
`endif

// File: hdl/ulb_uart.v
// The implementer's own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "ulb_consts.vh"
`default_nettype none
module ulb_uart #(
	parameter integer ADDR_W = 8
) (
	input wire sys_clk,
	input wire rst,
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire serial_in_pin,
	output reg serial_out_pin,
	output reg tx_enable_irq,
	output reg rx_done_irq
);
	// ---------------------------------------------------------------
	// Register bus
	// ---------------------------------------------------------------
	reg aw_full_r, w_full_r;
	reg [ADDR_W-1:0] aw_addr_r;
	reg [7:0] w_data_r;
	reg w_lane_r;
	reg [7:0] serial_ctrl0, serial_option0, tx_data_reg, rx_data_reg, div_r;
	reg overrun_flag, parity_err_flag, framing_err_flag;
	reg tx_buf_full_r, rx_full_r;
	wire wr_go = aw_full_r & w_full_r & ~s_axi_bvalid;
	wire rd_go = s_axi_arvalid & ~s_axi_rvalid;
	wire wr_en = wr_go & w_lane_r;
	wire unit_power_on = serial_ctrl0[`ULB_C_PWR];
	wire tx_enable_bit = serial_ctrl0[`ULB_C_TXE];
	wire rx_enable_bit = serial_ctrl0[`ULB_C_RXE];
	wire tx_on = unit_power_on & tx_enable_bit;
	wire rx_on = unit_power_on & rx_enable_bit;
	wire [1:0] par_mode = serial_ctrl0[`ULB_C_PS_HI:`ULB_C_PS_LO];
	wire len7 = serial_ctrl0[`ULB_C_LEN7];
	wire msb_first = serial_ctrl0[`ULB_C_MSB];
	wire break_tx_trigger = serial_option0[`ULB_O_STT];
	wire break_rx_flag = serial_option0[`ULB_O_SRF];
	wire tx_busy_flag;
	wire wr_tx = wr_en & (aw_addr_r == `ULB_A_TX);
	wire wr_opt = wr_en & (aw_addr_r == `ULB_A_OPT);
	wire wr_stat = wr_en & (aw_addr_r == `ULB_A_STAT);
	wire rd_rx = rd_go & (s_axi_araddr == `ULB_A_RX);

	// Decodes whether an address holds a register.
	function mapped;
		input [ADDR_W-1:0] a;
		begin
			mapped = (a == `ULB_A_CTRL) | (a == `ULB_A_OPT) |
				(a == `ULB_A_STAT) | (a == `ULB_A_TX) |
				(a == `ULB_A_RX) | (a == `ULB_A_DIV);
		end
	endfunction

	assign s_axi_awready = ~aw_full_r;
	assign s_axi_wready = ~w_full_r;
	assign s_axi_arready = ~s_axi_rvalid;

	// Address and data are caught in either order; the write fires once both are held.
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			aw_addr_r <= {ADDR_W{1'b0}};
			w_data_r <= 8'h00;
			w_lane_r <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ULB_RESP_OK;
		end else begin
			if (s_axi_awvalid & ~aw_full_r) begin
				aw_full_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid & ~w_full_r) begin
				w_full_r <= 1'b1;
				w_data_r <= s_axi_wdata[7:0];
				w_lane_r <= s_axi_wstrb[0];
			end
			if (wr_go) begin
				aw_full_r <= 1'b0;
				w_full_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(aw_addr_r) ? `ULB_RESP_OK : `ULB_RESP_ERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Read data is registered; reserved bits read as zero.
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `ULB_RESP_OK;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= mapped(s_axi_araddr) ? `ULB_RESP_OK : `ULB_RESP_ERR;
			case (s_axi_araddr)
			`ULB_A_CTRL: s_axi_rdata <= {24'h000000, serial_ctrl0};
			`ULB_A_OPT: s_axi_rdata <= {24'h000000, serial_option0};
			`ULB_A_STAT: s_axi_rdata <= {24'h000000, tx_busy_flag, 4'h0,
				parity_err_flag, framing_err_flag, overrun_flag};
			`ULB_A_TX: s_axi_rdata <= {24'h000000, tx_data_reg};
			`ULB_A_RX: s_axi_rdata <= {24'h000000, rx_data_reg};
			`ULB_A_DIV: s_axi_rdata <= {24'h000000, div_r};
			default: s_axi_rdata <= 32'h00000000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Transmitter
	// ---------------------------------------------------------------
	localparam [2:0] TS_IDLE = 3'h1;
	localparam [2:0] TS_SHIFT = 3'h2;
	localparam [2:0] TS_BRK = 3'h4;
	reg [2:0] tx_st_r;
	reg [7:0] tx_cnt_r;
	reg [3:0] tx_bits_r;
	reg [11:0] tx_sh_r;
	reg tx_line_r;
	reg [4:0] brk_len_r;
	wire tx_tick = (tx_cnt_r == div_r - 8'h01);
	wire [7:0] tx_src = msb_first ? {tx_data_reg[0], tx_data_reg[1],
		tx_data_reg[2], tx_data_reg[3], tx_data_reg[4], tx_data_reg[5],
		tx_data_reg[6], tx_data_reg[7]} : tx_data_reg;
	// Reversal already puts TX[7:1] in the low seven bits for MSB-first.
	wire [6:0] tx_d7 = tx_src[6:0];
	wire tx_par_d = len7 ? ^tx_d7 : ^tx_src;
	reg tx_par;
	reg [11:0] tx_frame;
	reg [3:0] tx_nbits;
	assign tx_busy_flag = (tx_st_r == TS_SHIFT) | tx_buf_full_r;

	// Build the outgoing frame; the shifter sends bit 0 first.
	always @* begin
		case (par_mode)
		`ULB_PS_ODD: tx_par = ~tx_par_d;
		`ULB_PS_EVEN: tx_par = tx_par_d;
		default: tx_par = 1'b0;
		endcase
		tx_frame = 12'hFFF;
		if (len7) begin
			tx_frame[7:0] = {tx_d7, 1'b0};
			if (par_mode != `ULB_PS_NONE)
				tx_frame[8] = tx_par;
		end else begin
			tx_frame[8:0] = {tx_src, 1'b0};
			if (par_mode != `ULB_PS_NONE)
				tx_frame[9] = tx_par;
		end
		tx_nbits = (len7 ? 4'h9 : 4'hA) +
			((par_mode != `ULB_PS_NONE) ? 4'h1 : 4'h0) +
			(serial_ctrl0[`ULB_C_STOP2] ? 4'h1 : 4'h0);
	end

	// Transmit sequencer: data frames and sync breaks share the line.
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			tx_st_r <= TS_IDLE;
			tx_cnt_r <= 8'h00;
			tx_bits_r <= 4'h0;
			tx_sh_r <= 12'hFFF;
			tx_line_r <= 1'b1;
			brk_len_r <= 5'h00;
			tx_enable_irq <= 1'b0;
		end else begin
			tx_enable_irq <= 1'b0;
			tx_cnt_r <= tx_tick ? 8'h00 : tx_cnt_r + 8'h01;
			if (!tx_on) begin
				tx_st_r <= TS_IDLE;
				tx_line_r <= 1'b1;
				tx_cnt_r <= 8'h00;
			end else begin
				case (tx_st_r)
				TS_IDLE: begin
					tx_line_r <= 1'b1;
					tx_cnt_r <= 8'h00;
					if (tx_buf_full_r) begin
						tx_st_r <= TS_SHIFT;
						tx_sh_r <= tx_frame;
						tx_bits_r <= tx_nbits;
						tx_line_r <= 1'b0;
						tx_enable_irq <= 1'b1;
					end else if (break_tx_trigger) begin
						tx_st_r <= TS_BRK;
						brk_len_r <= `ULB_BRK_BASE +
							{2'b00, serial_option0[`ULB_O_SBL_HI:`ULB_O_SBL_LO]
							+ 3'h3};
						tx_line_r <= 1'b0;
						tx_enable_irq <= 1'b1;
					end
				end
				TS_SHIFT: if (tx_tick) begin
					if (tx_bits_r == 4'h1) begin
						tx_st_r <= TS_IDLE;
						tx_line_r <= 1'b1;
					end else begin
						tx_sh_r <= {1'b1, tx_sh_r[11:1]};
						tx_line_r <= tx_sh_r[1];
						tx_bits_r <= tx_bits_r - 4'h1;
					end
				end
				TS_BRK: if (tx_tick) begin
					if (brk_len_r == 5'h01) begin
						tx_st_r <= TS_IDLE;
						tx_line_r <= 1'b1;
					end else begin
						brk_len_r <= brk_len_r - 5'h01;
					end
				end
				default: tx_st_r <= TS_IDLE;
				endcase
			end
		end
	end

	// Pin is held high unless the transmitter is on; the invert bit then flips idle and data alike.
	always @(posedge sys_clk or posedge rst) begin
		if (rst)
			serial_out_pin <= 1'b1;
		else if (!unit_power_on)
			serial_out_pin <= 1'b1;
		else if (!tx_on)
			serial_out_pin <= 1'b1;
		else
			serial_out_pin <= tx_line_r ^ serial_option0[`ULB_O_TINV];
	end

	// ---------------------------------------------------------------
	// Receiver
	// ---------------------------------------------------------------
	localparam [3:0] RS_WAIT = 4'h1;
	localparam [3:0] RS_START = 4'h2;
	localparam [3:0] RS_DATA = 4'h4;
	localparam [3:0] RS_BRK = 4'h8;
	reg rx_m_r, rx_s_r, rx_d_r;
	reg [3:0] rx_st_r;
	reg [7:0] rx_cnt_r;
	reg [3:0] rx_bits_r;
	reg [7:0] rx_sh_r;
	reg rx_par_r, rx_armed_r;
	reg [4:0] low_cnt_r;
	wire rx_tick = (rx_cnt_r == div_r - 8'h01);
	wire rx_mid = (rx_cnt_r == {1'b0, div_r[7:1]});
	wire has_par = (par_mode != `ULB_PS_NONE);
	wire [3:0] rx_nbits = (len7 ? 4'h7 : 4'h8) + (has_par ? 4'h1 : 4'h0);
	wire [7:0] rx_word = !len7 ? rx_sh_r :
		(msb_first ? {rx_sh_r[6:0], 1'b0} : {1'b0, rx_sh_r[7:1]});
	reg rx_done, rx_pe, rx_fe, rx_ove;

	// Two flops guard against the asynchronous pin; rx_s_r and its delayed copy rx_d_r are used.
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rx_m_r <= 1'b1;
			rx_s_r <= 1'b1;
			rx_d_r <= 1'b1;
		end else begin
			rx_m_r <= serial_in_pin;
			rx_s_r <= rx_m_r;
			rx_d_r <= rx_s_r;
		end
	end

	// Receive sequencer: one bit counter, sampling at each bit's centre.
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rx_st_r <= RS_WAIT;
			rx_cnt_r <= 8'h00;
			rx_bits_r <= 4'h0;
			rx_sh_r <= `ULB_RST_DATA;
			rx_par_r <= 1'b0;
			rx_armed_r <= 1'b0;
			low_cnt_r <= 5'h00;
			rx_done <= 1'b0;
			rx_pe <= 1'b0;
			rx_fe <= 1'b0;
			rx_ove <= 1'b0;
		end else begin
			rx_done <= 1'b0;
			rx_pe <= 1'b0;
			rx_fe <= 1'b0;
			rx_ove <= 1'b0;
			rx_cnt_r <= rx_tick ? 8'h00 : rx_cnt_r + 8'h01;
			if (!rx_on) begin
				rx_st_r <= RS_WAIT;
				rx_armed_r <= 1'b0;
			end else begin
				case (rx_st_r)
				RS_WAIT: begin
					rx_cnt_r <= 8'h00;
					if (rx_s_r)
						rx_armed_r <= 1'b1;
					if (rx_armed_r & rx_d_r & ~rx_s_r) begin
						rx_st_r <= RS_START;
						rx_armed_r <= 1'b0;
					end
				end
				RS_START: if (rx_mid) begin
					if (rx_s_r) begin
						rx_st_r <= RS_WAIT;
					end else if (break_rx_flag) begin
						rx_st_r <= RS_BRK;
						low_cnt_r <= 5'h01;
						rx_sh_r <= `ULB_RST_DATA;
					end else begin
						rx_st_r <= RS_DATA;
						rx_sh_r <= `ULB_RST_DATA;
						rx_par_r <= 1'b0;
						rx_bits_r <= rx_nbits;
					end
				end
				RS_DATA: if (rx_mid) begin
					if (rx_bits_r == 4'h0) begin
						rx_st_r <= RS_WAIT;
						rx_done <= 1'b1;
						rx_fe <= ~rx_s_r;
						rx_ove <= rx_full_r;
						case (par_mode)
						`ULB_PS_ODD: rx_pe <= ~rx_par_r;
						`ULB_PS_EVEN: rx_pe <= rx_par_r;
						default: rx_pe <= 1'b0;
						endcase
					end else begin
						rx_par_r <= rx_par_r ^ rx_s_r;
						if (!(has_par & (rx_bits_r == 4'h1)))
							rx_sh_r <= msb_first ? {rx_sh_r[6:0], rx_s_r} :
								{rx_s_r, rx_sh_r[7:1]};
						rx_bits_r <= rx_bits_r - 4'h1;
					end
				end
				RS_BRK: if (rx_mid) begin
					if (rx_s_r) begin
						rx_st_r <= RS_WAIT;
					end else if (low_cnt_r != 5'h1F) begin
						low_cnt_r <= low_cnt_r + 5'h01;
					end
				end
				default: rx_st_r <= RS_WAIT;
				endcase
			end
		end
	end

	// A break is valid when the line first rises after enough low bits.
	wire brk_ok = rx_on & (rx_st_r == RS_BRK) & rx_mid & rx_s_r &
		(low_cnt_r >= `ULB_BRK_RX_MIN);

	// Receive interrupt and data hand-off; breaks bypass the data path.
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rx_done_irq <= 1'b0;
			rx_data_reg <= `ULB_RST_DATA;
			rx_full_r <= 1'b0;
		end else begin
			rx_done_irq <= (rx_done & rx_on) | brk_ok;
			if (!unit_power_on) begin
				rx_data_reg <= `ULB_RST_DATA;
				rx_full_r <= 1'b0;
			end else if (rx_done & rx_on & ~rx_ove) begin
				rx_data_reg <= rx_word;
				rx_full_r <= 1'b1;
			end else if (rd_rx) begin
				rx_full_r <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// Control and status registers
	// ---------------------------------------------------------------
	// A hardware set of an error flag wins over a same-cycle software clear.
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			overrun_flag <= 1'b0;
			parity_err_flag <= 1'b0;
			framing_err_flag <= 1'b0;
		end else if (!rx_on) begin
			overrun_flag <= 1'b0;
			parity_err_flag <= 1'b0;
			framing_err_flag <= 1'b0;
		end else begin
			overrun_flag <= (rx_done & rx_ove) |
				(overrun_flag & ~(wr_stat & ~w_data_r[`ULB_S_OVE]));
			parity_err_flag <= (rx_done & rx_pe) |
				(parity_err_flag & ~(wr_stat & ~w_data_r[`ULB_S_PE]));
			framing_err_flag <= (rx_done & rx_fe) |
				(framing_err_flag & ~(wr_stat & ~w_data_r[`ULB_S_FE]));
		end
	end

	// Software settings; triggers are cleared by hardware when served.
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			serial_ctrl0 <= `ULB_RST_CTRL;
			serial_option0 <= `ULB_RST_OPT;
			tx_data_reg <= `ULB_RST_DATA;
			div_r <= `ULB_RST_DIV;
			tx_buf_full_r <= 1'b0;
		end else begin
			if (wr_en & (aw_addr_r == `ULB_A_CTRL))
				serial_ctrl0 <= w_data_r;
			if (wr_en & (aw_addr_r == `ULB_A_DIV))
				div_r <= w_data_r;
			if (wr_tx)
				tx_data_reg <= w_data_r;
			if (wr_opt) begin
				serial_option0[3:0] <= w_data_r[3:0];
				if (w_data_r[`ULB_O_STT] & tx_on)
					serial_option0[`ULB_O_STT] <= 1'b1;
				if (w_data_r[`ULB_O_SRF] & rx_on)
					serial_option0[`ULB_O_SRF] <= 1'b1;
			end
			if (!tx_on | ((tx_st_r == TS_BRK) & tx_tick &
				(brk_len_r == 5'h01)))
				serial_option0[`ULB_O_STT] <= 1'b0;
			if (!rx_on | brk_ok)
				serial_option0[`ULB_O_SRF] <= 1'b0;
			if (!tx_on)
				tx_buf_full_r <= 1'b0;
			else if (wr_tx)
				tx_buf_full_r <= 1'b1;
			else if (tx_st_r == TS_IDLE)
				tx_buf_full_r <= 1'b0;
		end
	end
endmodule // ulb_uart
`default_nettype wire

// File: sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ulb_consts.vh"
module tb_top;
	localparam int BIT = 16;
	logic sys_clk, rst, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata;
	wire awready, wready, bvalid, arready, rvalid, sin, sout, txi, rxi;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	int n_errors = 0, compares = 0, cycles = 0, n_txi = 0, n_rxi = 0;
	int run = 0, last_low = 0, t0, len;
	logic [3:0] k;
	ulb_uart #(.ADDR_W(8)) ulb_uart_i (
		.sys_clk(sys_clk), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.serial_in_pin(sin), .serial_out_pin(sout),
		.tx_enable_irq(txi), .rx_done_irq(rxi)
	);
	ulb_remote_node #(.BIT(BIT)) ulb_remote_node_i (
		.sys_clk(sys_clk), .line_in(sout), .line_out(sin)
	);
	// The clock free-runs at 40 MHz.
	initial begin
		sys_clk = 1'b0;
		forever #12.5 sys_clk = ~sys_clk;
	end
	task conclude;
		if (n_errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task chk_cnt(input int got, input int exp);
		compares++;
		if (got != exp) begin
			n_errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Addresses past the divisor are unmapped and answer with an error.
	task wr(input logic [7:0] a, input logic [7:0] d);
		logic aw_ok, w_ok;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= {24'h0, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		while (!(aw_ok && w_ok)) begin
			@(posedge sys_clk);
			if (awvalid === 1'b1 && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (wvalid === 1'b1 && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge sys_clk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk({30'h0, bresp}, (a > 8'h14) ? 32'h2 : 32'h0);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge sys_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge sys_clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk(rdata, {24'h0, e});
		chk({30'h0, rresp}, (a > 8'h14) ? 32'h2 : 32'h0);
	endtask
	// One frame from the far side with a chosen stop level, then idle.
	task rxf(input logic [7:0] d, input logic stop);
		ulb_remote_node_i.send({10'h0, stop, d, 1'b0}, 10);
		repeat (BIT) @(posedge sys_clk);
	endtask
	// Irq counts, low-stretch lengths and the hang limit.
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		n_txi <= n_txi + ((txi === 1'b1) ? 1 : 0);
		n_rxi <= n_rxi + ((rxi === 1'b1) ? 1 : 0);
		run <= (sout === 1'b0) ? run + 1 : 0;
		if (sout === 1'b1 && run != 0)
			last_low <= run;
		if (cycles == 20000) begin
			n_errors++;
			conclude();
		end
	end
	// Main sequence.
	initial begin
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		rd(`ULB_A_CTRL, 8'h00);
		rd(`ULB_A_OPT, 8'h05);
		rd(`ULB_A_STAT, 8'h00);
		rd(`ULB_A_TX, 8'hFF);
		rd(`ULB_A_RX, 8'hFF);
		rd(`ULB_A_DIV, 8'hFF);
		rd(8'h18, 8'h00);
		wr(8'h18, 8'h5A);
		wr(`ULB_A_DIV, BIT[7:0]);
		wr(`ULB_A_CTRL, 8'h07);
		chk({31'h0, sout}, 32'h1);
		// Second byte is loaded as soon as the first one starts shifting.
		wr(`ULB_A_TX, 8'hA5);
		while (n_txi < 1) @(posedge sys_clk);
		wr(`ULB_A_TX, 8'h5A);
		rd(`ULB_A_STAT, 8'h80);
		while (ulb_remote_node_i.rx_q.size() < 2) @(posedge sys_clk);
		chk({24'h0, ulb_remote_node_i.rx_q[0]}, 32'hA5);
		chk({24'h0, ulb_remote_node_i.rx_q[1]}, 32'h5A);
		repeat (2 * BIT) @(posedge sys_clk);
		rd(`ULB_A_STAT, 8'h00);
		chk_cnt(n_txi, 2);
		// Every break length code in turn.
		for (k = 0; k < 8; k++) begin
			len = ((k + 3) % 8) + 13;
			wr(`ULB_A_OPT, {4'h1, k});
			repeat (len * BIT + 16) @(posedge sys_clk);
			chk_cnt(last_low, len * BIT);
			rd(`ULB_A_OPT, {4'h0, k});
		end
		chk_cnt(n_txi, 10);
		// The invert bit flips the idle level too while enabled.
		wr(`ULB_A_OPT, 8'h0D);
		@(posedge sys_clk);
		chk({31'h0, sout}, 32'h0);
		wr(`ULB_A_OPT, 8'h05);
		@(posedge sys_clk);
		chk({31'h0, sout}, 32'h1);
		rxf(8'h3C, 1'b1);
		rd(`ULB_A_RX, 8'h3C);
		rd(`ULB_A_STAT, 8'h00);
		// Unread data makes the next frame an overrun.
		rxf(8'h11, 1'b1);
		rxf(8'h22, 1'b1);
		rd(`ULB_A_STAT, 8'h01);
		rd(`ULB_A_RX, 8'h11);
		wr(`ULB_A_STAT, 8'hFF);
		rd(`ULB_A_STAT, 8'h01);
		wr(`ULB_A_STAT, 8'h00);
		rd(`ULB_A_STAT, 8'h00);
		rxf(8'h55, 1'b0);
		rd(`ULB_A_STAT, 8'h02);
		rd(`ULB_A_RX, 8'h55);
		wr(`ULB_A_STAT, 8'h00);
		// Two-stop mode with single-stop frames back to back.
		wr(`ULB_A_CTRL, 8'h47);
		ulb_remote_node_i.send({1'b1, 8'h77, 2'h1, 8'h66, 1'b0}, 20);
		repeat (BIT) @(posedge sys_clk);
		rd(`ULB_A_STAT, 8'h01);
		rd(`ULB_A_RX, 8'h66);
		wr(`ULB_A_STAT, 8'h00);
		// Even parity with a wrong parity bit.
		wr(`ULB_A_CTRL, 8'h1F);
		ulb_remote_node_i.send({9'h0, 2'h2, 8'h01, 1'b0}, 11);
		repeat (BIT) @(posedge sys_clk);
		rd(`ULB_A_STAT, 8'h04);
		rd(`ULB_A_RX, 8'h01);
		wr(`ULB_A_STAT, 8'h00);
		// Seven-bit MSB-first frames both ways: TX[7:1] leaves first-bit-MSB.
		wr(`ULB_A_CTRL, 8'hA7);
		wr(`ULB_A_TX, 8'hB4);
		ulb_remote_node_i.send({11'h0, 9'h15A}, 9);
		repeat (2 * BIT) @(posedge sys_clk);
		chk({24'h0, ulb_remote_node_i.rx_q[2]}, 32'hAD);
		rd(`ULB_A_RX, 8'hB4);
		// Break wait: eleven low bits pass, ten do not.
		wr(`ULB_A_CTRL, 8'h07);
		wr(`ULB_A_OPT, 8'h25);
		t0 = n_rxi;
		ulb_remote_node_i.send(20'h0, 11);
		repeat (2 * BIT) @(posedge sys_clk);
		chk_cnt(n_rxi, t0 + 1);
		rd(`ULB_A_OPT, 8'h05);
		rd(`ULB_A_STAT, 8'h00);
		rd(`ULB_A_RX, 8'hB4);
		wr(`ULB_A_OPT, 8'h25);
		ulb_remote_node_i.send(20'h0, 10);
		repeat (2 * BIT) @(posedge sys_clk);
		chk_cnt(n_rxi, t0 + 1);
		rd(`ULB_A_OPT, 8'h25);
		wr(`ULB_A_CTRL, 8'h00);
		rd(`ULB_A_RX, 8'hFF);
		rd(`ULB_A_OPT, 8'h05);
		conclude();
	end
endmodule // tb_top
bind ulb_uart ulb_uart_props ulb_uart_props_i (
	.sys_clk(sys_clk), .rst(rst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .serial_out_pin(serial_out_pin),
	.tx_enable_irq(tx_enable_irq), .rx_done_irq(rx_done_irq)
);
`default_nettype wire

// File: sim/ulb_remote_node.sv
`timescale 1ns/1ps
`default_nettype none
module ulb_remote_node #(
	parameter int BIT = 16
) (
	input wire logic sys_clk,
	input wire logic line_in,
	output logic line_out
);
	logic [7:0] rx_q[$];
	logic [7:0] sh;
	int i;
	initial line_out = 1'b1;
	// Sends n bits first-bit-first, then leaves the line at its idle high.
	task automatic send(input logic [19:0] b, input int n);
		for (int k = 0; k < n; k++) begin
			line_out <= b[k];
			repeat (BIT) @(posedge sys_clk);
		end
		line_out <= 1'b1;
	endtask
	// Frames with a low stop sample, breaks included, are dropped.
	always begin
		@(negedge line_in);
		repeat (BIT / 2) @(posedge sys_clk);
		if (line_in === 1'b0) begin
			for (i = 0; i < 8; i++) begin
				repeat (BIT) @(posedge sys_clk);
				sh[i] = line_in;
			end
			repeat (BIT) @(posedge sys_clk);
			if (line_in === 1'b1)
				rx_q.push_back(sh);
		end
		wait (line_in === 1'b1);
	end
endmodule // ulb_remote_node
`default_nettype wire

// File: sim/ulb_uart_props.sv
`timescale 1ns/1ps
`default_nettype none
module ulb_uart_props (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic serial_out_pin,
	input wire logic tx_enable_irq,
	input wire logic rx_done_irq
);
	// All checks share one clock and sleep while reset is high.
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	sequence s_wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	// Four cycles is the smallest usable bit time, so any start is that long.
	sequence s_start_low;
		!serial_out_pin [*4];
	endsequence
	property p_wr_resp;
		s_wr_take |-> ##[1:2] s_axi_bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write answer late");
	property p_b_drop;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_b_drop: assert property (p_b_drop) else $error("write answer held");
	property p_r_drop;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_r_drop: assert property (p_r_drop) else $error("read answer held");
	property p_ar_block;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("read taken early");
	property p_rd_resp;
		s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
	endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("read answer late");
	property p_rd_err;
		s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0;
	endproperty
	a_rd_err: assert property (p_rd_err) else $error("error read has data");
	property p_tx_pulse;
		tx_enable_irq |=> !tx_enable_irq;
	endproperty
	a_tx_pulse: assert property (p_tx_pulse) else $error("tx irq too long");
	property p_rx_pulse;
		rx_done_irq |=> !rx_done_irq;
	endproperty
	a_rx_pulse: assert property (p_rx_pulse) else $error("rx irq too long");
	property p_tx_start;
		tx_enable_irq |-> ##[0:2] s_start_low;
	endproperty
	a_tx_start: assert property (p_tx_start) else $error("no low after irq");
endmodule // ulb_uart_props
`default_nettype wire
